// *** rtl/mpfc_defines.svh ***
// Purpose: offsets, field positions and counts of the pin function block
// Assumes: APB byte addresses, one 32-bit word per register
// Notes: included by the top module, the checker and the test bench
`ifndef MPFC_DEFINES_SVH
`define MPFC_DEFINES_SVH
`define MPFC_A_USB_CONTROL_STATUS   8'h00
`define MPFC_A_CPU_CONTROL_STATUS   8'h04
`define MPFC_A_BPCTL   8'h08
`define MPFC_A_BPADR   8'h0C
`define MPFC_A_PAFS    8'h10
`define MPFC_A_PAFS2   8'h14
`define MPFC_A_IFCFG   8'h18
`define MPFC_A_PAOUT   8'h1C
`define MPFC_A_PADIR   8'h20
`define MPFC_A_STAT    8'h24
`define MPFC_USB_OE    2
`define MPFC_USB_LVL   3
`define MPFC_CPU_CKZ   1
`define MPFC_BP_FLAG   0
`define MPFC_BP_EN     1
`define MPFC_BP_PULSE  2
`define MPFC_IF_ALT    3
`define MPFC_IF_RDALT  4
`define MPFC_IF_WCLK   7
`define MPFC_CFG_INV   1
`define MPFC_CFG_FAST  2
`define MPFC_BOUNDARY  16'h1B40
`define MPFC_BP_LEN    4'h8
`define MPFC_MODE_PROGRAMMABLE_WAVEFORM_ENGINE 2'h2
`define MPFC_MODE_SLV  2'h3
`endif

// *** rtl/mpfc_pkg.sv ***
// Purpose: types of the pin function block
// Assumes: constants come from mpfc_defines.svh
// Notes: all module state is one packed struct
package mpfc_pkg;
    typedef struct packed {
        logic [15:0] addr;
        logic        fetch;
        logic        ext_rd;
        logic        ext_wr;
        logic [7:0]  wdata;
    } mpfc_cpu_s;
    typedef struct packed {
        logic [15:0] addr;
        logic        active;
    } mpfc_dma_s;
    typedef struct packed {
        logic [1:0] full_ovf;
        logic [1:0] low_ovf;
        logic [1:0] split;
    } mpfc_tmr_s;
    typedef struct packed {
        logic [7:0]  usb_control_status;
        logic [7:0]  cpu_control_status;
        logic [7:0]  bpctl;
        logic [15:0] bpadr;
        logic [7:0]  pafs;
        logic [7:0]  pafs2;
        logic [7:0]  ifcfg;
        logic [4:0]  paout;
        logic [4:0]  padir;
        logic [7:0]  boot;
        logic        boot_done;
        logic [1:0]  rst_s;
        logic [1:0]  ea_s;
        logic [5:0]  pa_s1;
        logic [5:0]  pa_s2;
        logic [7:0]  d_s1;
        logic [7:0]  d_s2;
        logic [3:0]  bp_cnt;
        logic        bp_hit_q;
        logic [1:0]  ck_div;
        logic        ck_lvl;
        logic [2:0]  t0_cnt;
        logic [2:0]  t1_cnt;
        logic [7:0]  d_out;
        logic        d_oe_n;
        logic [15:0] a_out;
        logic        code_fetch_strobe_n_n;
        logic [31:0] prdata;
    } mpfc_state_s;
endpackage : mpfc_pkg

// *** rtl/mpfc_top.sv ***
// Functional notes
// - attach pin floats unless enable bit set
// - driven attach level inverts level bit
// - address bus always driven, cpu or dma
// - data bus drives writes, low in suspend
// - code strobe low on external fetch
// - live select pin picks code source
// - breakpoint high on enabled address match
// - pulse mode gives eight cycle pulse
// - level mode holds until flag cleared
// - active low reset clears everything
// - clock output rate from boot bit two
// - boot bit one inverts clock output
// - absent boot memory gives zero config
// - control bit one floats clock output
// - engine clock select independent of cpu
// - overflow outputs pulse one clock period
// - port a 0/1 carry timer outputs
// - port a pins come out of reset as inputs
// - port a 3/2 memory select and enable
// - port a 4 four way selection
// - ready input 4 from any pin set
// Purpose: pin function control with APB registers
// Assumes: cpu, dma and timer inputs are on sys_clk
// Notes: pin inputs pass two flip-flops; oe_n low means driving
//
// The implementer's own choices: the APB register port and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "mpfc_defines.svh"
module mpfc_top
    import mpfc_pkg::*;
(
    input  wire logic        sys_clk,
    input  wire logic        rst_n,
    input  wire logic        ce,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire mpfc_cpu_s   cpu,
    input  wire mpfc_dma_s   dma,
    input  wire mpfc_tmr_s   tmr,
    input  wire logic        suspend,
    input  wire logic        boot_present,
    input  wire logic [7:0]  boot_config_byte,
    input  wire logic        ext_code_pin,
    output logic             external_code_select,
    output logic             usb_attach_drive_n_o,
    output logic             usb_attach_drive_n_oe_n,
    output logic [15:0]      ext_addr,
    input  wire logic [7:0]  ext_data_i,
    output logic [7:0]       ext_data_o,
    output logic             ext_data_oe_n,
    output logic [7:0]       ext_rdata,
    output logic             code_fetch_strobe_n,
    output logic             breakpoint_out,
    output logic             cpu_clock_output,
    output logic             cpu_clock_output_oe_n,
    output logic             cpu_fast,
    output logic             engine_clk_ext_sel,
    input  wire logic [4:0]  pa_i,
    output logic [4:0]       pa_o,
    output logic [4:0]       pa_oe_n,
    input  wire logic        ready_input_4_alt_pin,
    input  wire logic        ext_fifo_write_strobe_n,
    input  wire logic        ext_mem_cs_n,
    input  wire logic        ext_mem_oe_n,
    output logic             ready_input_4,
    output logic             slave_fifo_write_strobe
);
    mpfc_state_s q;
    mpfc_state_s d;
    logic        srst_n;
    logic        wr_en;
    logic        rd_en;
    logic        hit;
    logic        ext_code;
    logic        bp_match;
    logic        t0_ev;
    logic        t1_ev;
    logic [2:0]  tper;
    logic        sel_t0;
    logic        sel_t1;
    logic        sel_oe;
    logic        sel_cs;
    logic        sel_fwr;
    logic        sel_rdy;
    logic        sel_slw;
    logic [31:0] rd_val;

    // reset leaves through two flops; the copy drives everything
    assign srst_n = q.rst_s[1];
    assign wr_en  = psel && penable && pwrite;
    assign rd_en  = psel && !penable && !pwrite;
    // zero wait states: every access ends in its first access cycle
    assign pready = 1'b1;

    always_comb
    begin
        hit    = 1'b1;
        rd_val = 32'h0000_0000;
        if (paddr == `MPFC_A_USB_CONTROL_STATUS)
            rd_val = {24'h00_0000, q.usb_control_status};
        else if (paddr == `MPFC_A_CPU_CONTROL_STATUS)
            rd_val = {24'h00_0000, q.cpu_control_status};
        else if (paddr == `MPFC_A_BPCTL)
            rd_val = {24'h00_0000, q.bpctl};
        else if (paddr == `MPFC_A_BPADR)
            rd_val = {16'h0000, q.bpadr};
        else if (paddr == `MPFC_A_PAFS)
            rd_val = {24'h00_0000, q.pafs};
        else if (paddr == `MPFC_A_PAFS2)
            rd_val = {24'h00_0000, q.pafs2};
        else if (paddr == `MPFC_A_IFCFG)
            rd_val = {24'h00_0000, q.ifcfg};
        else if (paddr == `MPFC_A_PAOUT)
            rd_val = {27'h000_0000, q.paout};
        else if (paddr == `MPFC_A_PADIR)
            rd_val = {27'h000_0000, q.padir};
        else if (paddr == `MPFC_A_STAT)
            rd_val = {14'h0000, q.ea_s[1], q.pa_s2, q.boot_done, q.boot, 2'h0};
        else
            hit = 1'b0;
    end
    assign pslverr = psel && penable && !hit;

    // code source: live pin, or at/above the boundary
    assign ext_code = q.ea_s[1] || (cpu.addr >= `MPFC_BOUNDARY);
    assign bp_match = q.bpctl[`MPFC_BP_EN] && (cpu.addr == q.bpadr);
    // a split-mode timer reports its low byte overflow
    assign t0_ev = tmr.split[0] ? tmr.low_ovf[0] : tmr.full_ovf[0];
    assign t1_ev = tmr.split[1] ? tmr.low_ovf[1] : tmr.full_ovf[1];
    // one output clock period in sys_clk cycles
    assign tper = q.boot[`MPFC_CFG_FAST] ? 3'h2 : 3'h4;

    always_comb
    begin
        sel_t0  = q.pafs[0] && q.ifcfg[`MPFC_IF_ALT];
        sel_t1  = q.pafs[1] && q.ifcfg[`MPFC_IF_ALT];
        sel_oe  = q.pafs[2] && q.ifcfg[`MPFC_IF_ALT];
        sel_cs  = q.pafs[3];
        sel_slw = q.pafs2[4] && (q.ifcfg[1:0] == `MPFC_MODE_SLV);
        sel_rdy = q.pafs[4] && !sel_slw && (q.ifcfg[1:0] == `MPFC_MODE_PROGRAMMABLE_WAVEFORM_ENGINE);
        sel_fwr = q.pafs[4] && !sel_slw && !sel_rdy;
    end

    always_comb
    begin
        d = q;
        d.rst_s = {q.rst_s[0], 1'b1};
        d.ea_s  = {q.ea_s[0], ext_code_pin};
        d.pa_s1 = {ready_input_4_alt_pin, pa_i};
        d.pa_s2 = q.pa_s1;
        d.d_s1  = ext_data_i;
        d.d_s2  = q.d_s1;
        // boot byte caught once after release; absent memory gives zero
        if (!q.boot_done)
        begin
            d.boot_done = 1'b1;
            d.boot = boot_present ? boot_config_byte : 8'h00;
        end
        if (wr_en)
        begin
            if (paddr == `MPFC_A_USB_CONTROL_STATUS)
                d.usb_control_status = pwdata[7:0];
            else if (paddr == `MPFC_A_CPU_CONTROL_STATUS)
                d.cpu_control_status = pwdata[7:0];
            else if (paddr == `MPFC_A_BPCTL)
                d.bpctl = {pwdata[7:1], q.bpctl[`MPFC_BP_FLAG] & ~pwdata[0]};
            else if (paddr == `MPFC_A_BPADR)
                d.bpadr = pwdata[15:0];
            else if (paddr == `MPFC_A_PAFS)
                d.pafs = pwdata[7:0];
            else if (paddr == `MPFC_A_PAFS2)
                d.pafs2 = pwdata[7:0];
            else if (paddr == `MPFC_A_IFCFG)
                d.ifcfg = pwdata[7:0];
            else if (paddr == `MPFC_A_PAOUT)
                d.paout = pwdata[4:0];
            else if (paddr == `MPFC_A_PADIR)
                d.padir = pwdata[4:0];
        end
        if (rd_en)
            d.prdata = rd_val;
        // new match on its rising edge only; set beats a same-cycle clear
        d.bp_hit_q = bp_match;
        if (bp_match && !q.bp_hit_q)
        begin
            d.bpctl[`MPFC_BP_FLAG] = 1'b1;
            d.bp_cnt = `MPFC_BP_LEN;
        end
        else if (q.bp_cnt != 4'h0)
            d.bp_cnt = q.bp_cnt - 4'h1;
        // clock output: fast toggles every cycle, slow every other
        d.ck_div = q.ck_div + 2'h1;
        if (q.boot[`MPFC_CFG_FAST] || q.ck_div[0])
            d.ck_lvl = ~q.ck_lvl;
        if (t0_ev)
            d.t0_cnt = tper;
        else if (q.t0_cnt != 3'h0)
            d.t0_cnt = q.t0_cnt - 3'h1;
        if (t1_ev)
            d.t1_cnt = tper;
        else if (q.t1_cnt != 3'h0)
            d.t1_cnt = q.t1_cnt - 3'h1;
        // address bus never floats
        d.a_out = dma.active ? dma.addr : cpu.addr;
        // suspend forces the data bus low, else drive only on writes
        d.d_oe_n = !(suspend || cpu.ext_wr);
        d.d_out  = suspend ? 8'h00 : cpu.wdata;
        d.code_fetch_strobe_n_n = !(cpu.fetch && ext_code);
    end

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            q <= '0;
            q.d_oe_n <= 1'b1;
            q.code_fetch_strobe_n_n <= 1'b1;
        end
        else if (ce)
        begin
            if (!srst_n)
            begin
                q <= '0;
                q.rst_s <= d.rst_s;
                q.d_oe_n <= 1'b1;
                q.code_fetch_strobe_n_n <= 1'b1;
            end
            else
                q <= d;
        end
    end

    assign prdata = q.prdata;
    assign external_code_select = q.ea_s[1];
    // float below the enable bit, else drive the inverse of the level bit
    assign usb_attach_drive_n_oe_n = !q.usb_control_status[`MPFC_USB_OE];
    assign usb_attach_drive_n_o = !q.usb_control_status[`MPFC_USB_LVL];
    assign ext_addr = q.a_out;
    assign ext_data_o = q.d_out;
    assign ext_data_oe_n = q.d_oe_n;
    assign ext_rdata = q.d_s2;
    assign code_fetch_strobe_n = q.code_fetch_strobe_n_n;
    // pulse mode follows the counter, level mode the sticky flag
    assign breakpoint_out = q.bpctl[`MPFC_BP_PULSE] ? (q.bp_cnt != 4'h0)
                                                   : q.bpctl[`MPFC_BP_FLAG];
    assign cpu_fast = q.boot[`MPFC_CFG_FAST];
    assign cpu_clock_output = q.ck_lvl ^ q.boot[`MPFC_CFG_INV];
    assign cpu_clock_output_oe_n = q.cpu_control_status[`MPFC_CPU_CKZ];
    assign engine_clk_ext_sel = q.ifcfg[`MPFC_IF_WCLK];

    // port a outputs; all inputs after reset since dir and selects are zero
    always_comb
    begin
        pa_o    = q.paout;
        pa_oe_n = ~q.padir;
        if (sel_t0)
        begin
            pa_o[0]    = q.t0_cnt != 3'h0;
            pa_oe_n[0] = 1'b0;
        end
        if (sel_t1)
        begin
            pa_o[1]    = q.t1_cnt != 3'h0;
            pa_oe_n[1] = 1'b0;
        end
        if (sel_oe)
        begin
            pa_o[2]    = ext_mem_oe_n;
            pa_oe_n[2] = 1'b0;
        end
        if (sel_cs)
        begin
            pa_o[3]    = ext_mem_cs_n;
            pa_oe_n[3] = 1'b0;
        end
        if (sel_fwr)
        begin
            pa_o[4]    = ext_fifo_write_strobe_n;
            pa_oe_n[4] = 1'b0;
        end
        else if (sel_rdy || sel_slw)
            pa_oe_n[4] = 1'b1;
    end

    // either, both or neither pin may feed ready input 4
    assign ready_input_4 = (sel_rdy && q.pa_s2[4])
                         || (q.ifcfg[`MPFC_IF_RDALT] && q.pa_s2[5]);
    assign slave_fifo_write_strobe = sel_slw && q.pa_s2[4];
endmodule : mpfc_top
`default_nettype wire

// *** sim/mpfc_mem_model.sv ***
// Purpose: external memory seen on the data bus
// Assumes: read request level comes from the cpu side
// Notes: a released bus shows the inverse of its last value
`timescale 1ns/1ps
`default_nettype none
module mpfc_mem_model
(
    input  wire logic        sys_clk,
    input  wire logic        rd,
    input  wire logic [15:0] addr,
    output logic [7:0]       data
);
    initial data = 8'h00;
    always @(posedge sys_clk)
        data <= rd ? (addr[7:0] ^ 8'hA5) : ~data;
endmodule : mpfc_mem_model
`default_nettype wire

// *** sim/mpfc_top_chk.sv ***
// Purpose: port level checks of the pin function block
// Assumes: ce high whenever a check starts
// Notes: register writes show one edge after the access edge
`timescale 1ns/1ps
`default_nettype none
`include "mpfc_defines.svh"
module mpfc_top_chk
    import mpfc_pkg::*;
(
    input wire logic        sys_clk,
    input wire logic        rst_n,
    input wire logic        ce,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire mpfc_cpu_s   cpu,
    input wire mpfc_dma_s   dma,
    input wire logic        suspend,
    input wire logic        usb_attach_drive_n_oe_n,
    input wire logic [15:0] ext_addr,
    input wire logic [7:0]  ext_data_o,
    input wire logic        ext_data_oe_n,
    input wire logic        code_fetch_strobe_n,
    input wire logic        cpu_clock_output,
    input wire logic        cpu_fast
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    wire usb_wr = ce && psel && penable && pwrite && paddr == `MPFC_A_USB_CONTROL_STATUS;
    property p_attach_oe; usb_wr |=> usb_attach_drive_n_oe_n == !$past(pwdata[2]); endproperty
    a_attach_oe: assert property (p_attach_oe) else $error("attach enable wrong");
    property p_addr_cpu; ce && !dma.active |=> ext_addr == $past(cpu.addr); endproperty
    a_addr_cpu: assert property (p_addr_cpu) else $error("cpu address not shown");
    property p_addr_dma; ce && dma.active |=> ext_addr == $past(dma.addr); endproperty
    a_addr_dma: assert property (p_addr_dma) else $error("dma address not shown");
    property p_data_wr;
        ce && cpu.ext_wr && !suspend |=> !ext_data_oe_n && ext_data_o == $past(cpu.wdata);
    endproperty
    a_data_wr: assert property (p_data_wr) else $error("write data not driven");
    property p_data_susp; ce && suspend |=> !ext_data_oe_n && ext_data_o == 8'h00; endproperty
    a_data_susp: assert property (p_data_susp) else $error("bus not low in suspend");
    property p_code_fetch_strobe_n_idle; ce && !cpu.fetch |=> code_fetch_strobe_n; endproperty
    a_code_fetch_strobe_n_idle: assert property (p_code_fetch_strobe_n_idle) else $error("stray code strobe");
    property p_code_fetch_strobe_n_ext;
        ce && cpu.fetch && cpu.addr >= `MPFC_BOUNDARY |=> !code_fetch_strobe_n;
    endproperty
    a_code_fetch_strobe_n_ext: assert property (p_code_fetch_strobe_n_ext) else $error("missing code strobe");
    property p_clk_fast; ce && cpu_fast |=> cpu_clock_output != $past(cpu_clock_output); endproperty
    a_clk_fast: assert property (p_clk_fast) else $error("fast clock stalled");
endmodule : mpfc_top_chk
bind mpfc_top mpfc_top_chk u_chk (.sys_clk, .rst_n, .ce, .psel, .penable, .pwrite, .paddr,
    .pwdata, .cpu, .dma, .suspend, .usb_attach_drive_n_oe_n, .ext_addr, .ext_data_o,
    .ext_data_oe_n, .code_fetch_strobe_n, .cpu_clock_output, .cpu_fast);
`default_nettype wire

// *** sim/test_mcu_pin_function_control.sv ***
// Purpose: self-checking bench of the pin function block
// Assumes: apb answers without wait states
// Notes: ce held high; the alternate ready pin stays low except in the ready input 4 check
`timescale 1ns/1ps
`default_nettype none
`include "mpfc_defines.svh"
module test_mcu_pin_function_control
    import mpfc_pkg::*;
;
    logic        sys_clk = 1'b0, rst_n = 1'b0, ce = 1'b1, suspend = 1'b0, pready, pslverr;
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0, err_q, boot_present = 1'b0;
    logic [7:0]  paddr = 8'h00, boot_config_byte = 8'h00, ext_data_i, ext_data_o, ext_rdata;
    logic [31:0] pwdata = 32'h0, prdata, rd_q;
    mpfc_cpu_s   cpu = '0;
    mpfc_dma_s   dma = '0;
    mpfc_tmr_s   tmr = '0;
    logic        ext_code_pin = 1'b0, ready_input_4_alt_pin = 1'b0, ext_fifo_write_strobe_n = 1'b1;
    logic        ext_mem_cs_n = 1'b1, ext_mem_oe_n = 1'b1, external_code_select;
    logic        usb_attach_drive_n_o, usb_attach_drive_n_oe_n, ext_data_oe_n, ready_input_4;
    logic        code_fetch_strobe_n, breakpoint_out, cpu_clock_output, cpu_clock_output_oe_n;
    logic        cpu_fast, engine_clk_ext_sel, slave_fifo_write_strobe;
    logic [15:0] ext_addr;
    logic [4:0]  pa_i = 5'h00, pa_o, pa_oe_n;
    logic [3:0]  ck;
    int          err_count = 0, cmp_count = 0, cycles = 0, n;
    wire  [1:0]  mon = {breakpoint_out, pa_o[0]};
    always #12.5 sys_clk = ~sys_clk;
    mpfc_top DUT (.sys_clk, .rst_n, .ce, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .cpu, .dma, .tmr, .suspend, .boot_present, .boot_config_byte,
        .ext_code_pin, .external_code_select, .usb_attach_drive_n_o, .usb_attach_drive_n_oe_n,
        .ext_addr, .ext_data_i, .ext_data_o, .ext_data_oe_n, .ext_rdata, .code_fetch_strobe_n,
        .breakpoint_out, .cpu_clock_output, .cpu_clock_output_oe_n, .cpu_fast,
        .engine_clk_ext_sel, .pa_i, .pa_o, .pa_oe_n, .ready_input_4_alt_pin, .ext_fifo_write_strobe_n,
        .ext_mem_cs_n, .ext_mem_oe_n, .ready_input_4, .slave_fifo_write_strobe);
    mpfc_mem_model u_mem (.sys_clk, .rd(cpu.ext_rd), .addr(ext_addr), .data(ext_data_i));
    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : end_of_test
    task automatic chk(input logic [32:0] got, input logic [32:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            err_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        @(posedge sys_clk);
        while (pready !== 1'b1)
            @(posedge sys_clk);
        rd_q    = prdata;
        err_q   = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge sys_clk);
    endtask : apb
    // also serves as a 20 cycle wait
    task automatic cnt(input int b, output int k);
        k = 0;
        repeat (20)
        begin
            @(posedge sys_clk);
            if (mon[b] === 1'b1)
                k++;
        end
    endtask : cnt
    task automatic fetch(input logic [15:0] a, output logic s);
        cpu.fetch <= 1'b1;
        cpu.addr  <= a;
        @(posedge sys_clk);
        cpu.fetch <= 1'b0;
        @(posedge sys_clk);
        s = code_fetch_strobe_n;
    endtask : fetch
    // outputs are checked while reset is still held
    task automatic do_reset(input logic bp, input logic [7:0] cfg);
        rst_n            <= 1'b0;
        boot_present     <= bp;
        boot_config_byte <= cfg;
        repeat (12) @(posedge sys_clk);
        chk({pa_oe_n, ext_data_oe_n, usb_attach_drive_n_oe_n, code_fetch_strobe_n,
            breakpoint_out, cpu_clock_output_oe_n}, 10'h3FC);
        rst_n            <= 1'b1;
        repeat (8) @(posedge sys_clk);
    endtask : do_reset
    always @(posedge sys_clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 5000)
        begin
            err_count++;
            end_of_test();
        end
    end
    initial
    begin
        do_reset(1'b0, 8'hFF);
        chk(cpu_fast, 1'b0);
        for (int i = 0; i < 4; i++)
        begin
            @(posedge sys_clk);
            ck[i] = cpu_clock_output;
        end
        chk({ck[0] ^ ck[2], ck[1] ^ ck[3]}, 2'b11);
        apb(1'b0, `MPFC_A_STAT, 32'h0);
        chk(rd_q[9:2], 8'h00);
        apb(1'b0, 8'h40, 32'h0);
        chk({err_q, rd_q}, 33'h100000000);
        for (int i = 0; i < 4; i++)
        begin
            apb(1'b1, `MPFC_A_USB_CONTROL_STATUS, i << 2);
            chk(usb_attach_drive_n_oe_n, !i[0]);
            if (i[0])
                chk(usb_attach_drive_n_o, !i[1]);
        end
        for (int i = 0; i < 2; i++)
        begin
            apb(1'b1, `MPFC_A_CPU_CONTROL_STATUS, i << 1);
            chk(cpu_clock_output_oe_n, i[0]);
        end
        apb(1'b1, `MPFC_A_PADIR, 32'h1F);
        apb(1'b1, `MPFC_A_PAOUT, 32'h15);
        chk({pa_oe_n, pa_o}, 10'h015);
        apb(1'b1, `MPFC_A_BPADR, 32'h1234);
        for (int m = 0; m < 3; m++)
        begin
            apb(1'b1, `MPFC_A_BPCTL, m == 0 ? 32'h1 : (m == 1 ? 32'h7 : 32'h3));
            cpu.addr <= 16'h1234;
            @(posedge sys_clk);
            cpu.addr <= 16'h0000;
            cnt(1, n);
            chk(m == 2 ? breakpoint_out : n, m == 1 ? 8 : m == 2);
        end
        apb(1'b1, `MPFC_A_BPCTL, 32'h3);
        chk(breakpoint_out, 1'b0);
        for (int p = 0; p < 2; p++)
        begin
            ext_code_pin <= p[0];
            cnt(0, n);
            chk(external_code_select, p[0]);
            fetch(16'h1B3F, err_q);
            chk(err_q, !p[0]);
            fetch(16'h1B40, err_q);
            chk(err_q, 1'b0);
        end
        cpu.ext_wr <= 1'b1;
        cpu.wdata  <= 8'h5A;
        cnt(0, n);
        chk({ext_data_oe_n, ext_data_o}, 9'h05A);
        cpu.ext_wr <= 1'b0;
        suspend    <= 1'b1;
        cnt(0, n);
        chk({ext_data_oe_n, ext_data_o}, 9'h000);
        suspend    <= 1'b0;
        cpu.addr   <= 16'h0077;
        cpu.ext_rd <= 1'b1;
        cnt(0, n);
        chk({ext_data_oe_n, ext_rdata, ext_addr}, 25'h1D20077);
        cpu        <= '0;
        dma        <= '{16'hABCD, 1'b1};
        cnt(0, n);
        chk(ext_addr, 16'hABCD);
        dma.active <= 1'b0;
        apb(1'b1, `MPFC_A_IFCFG, 32'h88);
        chk({engine_clk_ext_sel, cpu_fast}, 2'b10);
        apb(1'b1, `MPFC_A_PAFS, 32'h1F);
        ext_mem_cs_n <= 1'b0;
        tmr.full_ovf <= 2'b11;
        @(posedge sys_clk);
        tmr.full_ovf <= 2'b00;
        cnt(0, n);
        chk(n, 4);
        chk({pa_o[4:2], pa_oe_n}, 8'hA0);
        pa_i[4] <= 1'b1;
        for (int md = 2; md < 4; md++)
        begin
            apb(1'b1, `MPFC_A_IFCFG, md);
            apb(1'b1, `MPFC_A_PAFS2, md == 3 ? 32'h10 : 32'h0);
            chk({pa_oe_n[4], md == 2 ? ready_input_4 : slave_fifo_write_strobe}, 2'b11);
        end
        // alternate pin alone must still reach ready input 4
        pa_i[4]      <= 1'b0;
        ready_input_4_alt_pin <= 1'b1;
        apb(1'b1, `MPFC_A_IFCFG, 32'h12);
        chk(ready_input_4, 1'b1);
        ready_input_4_alt_pin <= 1'b0;
        do_reset(1'b1, 8'h04);
        chk(cpu_fast, 1'b1);
        ck[0] = cpu_clock_output;
        do_reset(1'b1, 8'h06);
        chk(cpu_clock_output, !ck[0]);
        end_of_test();
    end
endmodule : test_mcu_pin_function_control
`default_nettype wire
